// *** inc/crc_pkg.sv ***
// constants and types for the programmable checksum generator
`default_nettype none
package crc_pkg;
  // register byte addresses
  localparam logic [11:0] ctrl_off      = 12'h000;
  localparam logic [11:0] poly_off      = 12'h004;
  localparam logic [11:0] word_port_off = 12'h008;
  localparam logic [11:0] aux_port_off  = 12'h00c;
  localparam logic [11:0] power_off     = 12'h010;
  // control field positions
  localparam int len_lsb      = 0;
  localparam int run_bit      = 4;
  localparam int empty_bit    = 6;
  localparam int full_bit     = 7;
  localparam int count_lsb    = 8;
  localparam int idle_bit     = 13;
  // power register bits
  localparam int sleep_bit    = 0;
  localparam int idle_req_bit = 1;
  // reset values
  localparam logic [3:0]  len_rst   = 4'h0;
  localparam logic [15:1] poly_rst  = 15'h0000;
  localparam logic [4:0]  count_rst = 5'h00;
  localparam logic        empty_rst = 1'b1;
  // depth selection
  localparam logic [3:0]  deep_len_max = 4'h7;
  localparam logic [4:0]  depth_short  = 5'h10;
  localparam logic [4:0]  depth_long   = 5'h08;

  typedef enum logic [1:0] {
    eng_idle  = 2'b00,
    eng_shift = 2'b01
  } eng_state_t;

  typedef struct packed {
    logic [3:0]  len;
    logic        run;
    logic        halt_in_idle;
    logic [15:1] terms;
  } crc_cfg_t;
endpackage
`default_nettype wire

// *** src/programmable_crc_generator.sv ***
// programmable checksum generator with word fifo and apb register access
//
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// RQ1: polynomial middle terms from fifteen enable bits, length from four-bit field
// RQ2: constant term always fed back; top term implied by register width
// RQ3: length field is length minus one; words are field plus one bits
// RQ4: fifo eight deep when length field above seven, else sixteen
// RQ5: data port takes byte writes; bits above word width ignored
// RQ6: writing the word's top byte adds one to the valid count
// RQ7: running with words pending moves one word into shifter, count minus one
// RQ8: shifter does two bits per clock, half word-width clocks per word, rounded up for odd widths
// RQ9: full flag at depth count, empty flag at zero count
// RQ10: write while full wraps count to zero, no interrupt
// RQ11: software waits a cycle after data write before reading count
// RQ12: interrupt pulse when count goes from one to zero
// RQ13: software waits for empty before reading result
// RQ14: software discards words by running until empty
// RQ15: software primes fifo, runs, tops up while below depth
// RQ16: run bit one starts shifting, zero stops it
// RQ17: sleep freezes all state except registers software reaches, until clocks return; the drain event flop is not frozen
// RQ18: idle freezes only when halt bit set; interrupt still passed on
// RQ19: count bits 12..8, full 7, empty 6 read-only; empty resets one
// RQ20: polynomial bit zero reads zero
// RQ21: feedback register of programmed width, data msb first
module programmable_crc_generator (
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // events
  output logic             word_drained
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  crc_pkg::crc_cfg_t      cfg_reg;
  logic [15:0]            fifo_reg [16];
  logic [3:0]             wr_ptr_reg;
  logic [3:0]             rd_ptr_reg;
  logic [4:0]             count_reg;
  logic [15:0]            crc_reg;
  logic [15:0]            sh_data_reg;
  logic [3:0]             sh_left_reg;
  crc_pkg::eng_state_t    eng_reg;
  logic                   sleep_reg;
  logic                   idle_reg;
  logic                   drained_reg;

  logic        wr_en;
  logic        rd_en;
  logic        frozen;
  logic [4:0]  depth;
  logic        full_flag;
  logic        empty_flag;
  logic        top_byte_hit;
  logic        push;
  logic        pop;
  logic [15:0] wmask;
  logic [15:0] crc_next;
  logic [15:0] sh_data_next;
  logic [4:0]  word_bits;
  logic        aux_wr;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !(paddr == crc_pkg::ctrl_off ||
                   paddr == crc_pkg::poly_off || paddr == crc_pkg::word_port_off ||
                   paddr == crc_pkg::aux_port_off || paddr == crc_pkg::power_off);

  // freeze gates the fifo pop and the shift engine; registers software reaches and the event flop are not gated
  assign frozen = sleep_reg || (idle_reg && cfg_reg.halt_in_idle); // RQ17 RQ18

  assign depth = (cfg_reg.len > crc_pkg::deep_len_max) ? crc_pkg::depth_long
                                                       : crc_pkg::depth_short; // RQ4
  assign full_flag  = (count_reg == depth);                                   // RQ9
  assign empty_flag = (count_reg == 5'h00);                                   // RQ9
  assign word_bits  = {1'b0, cfg_reg.len} + 5'h01;                            // RQ3
  assign wmask      = 16'hffff >> (5'h10 - word_bits);                        // RQ5

  // top lane decides the word boundary: byte 0 for short words, byte 1 otherwise
  assign top_byte_hit = (cfg_reg.len > crc_pkg::deep_len_max) ? pstrb[1] : pstrb[0]; // RQ6
  assign push = wr_en && !pslverr && (paddr == crc_pkg::word_port_off) && top_byte_hit;
  // a result preset stalls the engine, so no word may leave the fifo then
  assign aux_wr = wr_en && (paddr == crc_pkg::aux_port_off) && pstrb[0];
  assign pop  = !frozen && cfg_reg.run && !empty_flag && !aux_wr &&
                (eng_reg == crc_pkg::eng_idle || sh_left_reg <= 4'h1);       // RQ7

  // ---------------------------------------------------------------
  // configuration
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg <= '{len: crc_pkg::len_rst, run: 1'b0, halt_in_idle: 1'b0,
                   terms: crc_pkg::poly_rst};
    end else if (wr_en && !pslverr) begin
      if (paddr == crc_pkg::ctrl_off && pstrb[0]) begin
        cfg_reg.len <= pwdata[crc_pkg::len_lsb +: 4];                         // RQ1
        cfg_reg.run <= pwdata[crc_pkg::run_bit];                              // RQ16
      end
      if (paddr == crc_pkg::ctrl_off && pstrb[1]) begin
        cfg_reg.halt_in_idle <= pwdata[crc_pkg::idle_bit];
      end
      if (paddr == crc_pkg::poly_off) begin
        if (pstrb[0]) begin
          cfg_reg.terms[7:1] <= pwdata[7:1];                                  // RQ1
        end
        if (pstrb[1]) begin
          cfg_reg.terms[15:8] <= pwdata[15:8];
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_reg <= 1'b0;
      idle_reg  <= 1'b0;
    end else if (wr_en && paddr == crc_pkg::power_off && pstrb[0]) begin
      sleep_reg <= pwdata[crc_pkg::sleep_bit];
      idle_reg  <= pwdata[crc_pkg::idle_req_bit];
    end
  end

  // ---------------------------------------------------------------
  // fifo
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_entry
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          fifo_reg[gi] <= 16'h0000;
        end else begin
          if (wr_en && !pslverr && paddr == crc_pkg::word_port_off &&
              wr_ptr_reg == 4'(gi)) begin
            if (pstrb[0]) begin
              fifo_reg[gi][7:0] <= pwdata[7:0] & wmask[7:0];                  // RQ5
            end
            if (pstrb[1]) begin
              fifo_reg[gi][15:8] <= pwdata[15:8] & wmask[15:8];
            end
          end
        end
      end
    end
  endgenerate

  // a push while full restarts the fifo at empty; no drain event follows
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_reg <= 4'h0;
      rd_ptr_reg <= 4'h0;
      count_reg  <= crc_pkg::count_rst;
    end else if (push && full_flag) begin
      wr_ptr_reg <= 4'h0;                                                     // RQ10
      rd_ptr_reg <= 4'h0;
      count_reg  <= 5'h00;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg + 4'h1) & 4'(depth - 5'h01);
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg + 4'h1) & 4'(depth - 5'h01);
      end
      if (push && !pop) begin
        count_reg <= count_reg + 5'h01;                                       // RQ6
      end else if (pop && !push) begin
        count_reg <= count_reg - 5'h01;                                       // RQ7
      end
    end
  end

  // event flop is not gated by freeze, but it needs a pop, which freeze blocks, so no event while frozen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drained_reg <= 1'b0;
    end else begin
      drained_reg <= pop && !push && (count_reg == 5'h01);                    // RQ12 RQ18
    end
  end
  assign word_drained = drained_reg;

  // ---------------------------------------------------------------
  // shift engine
  // ---------------------------------------------------------------
  // two steps of a register of width len+1, data msb first
  always_comb begin
    logic fb;
    fb           = 1'b0;
    crc_next     = crc_reg;
    sh_data_next = sh_data_reg;
    for (int s = 0; s < 2; s++) begin
      // odd widths take a single step in the word's last cycle
      if (s == 0 || sh_left_reg != 4'h1 || word_bits[0] == 1'b0) begin          // RQ8
        fb = crc_next[cfg_reg.len] ^ sh_data_next[cfg_reg.len];               // RQ21
        crc_next     = (crc_next << 1) & wmask;
        sh_data_next = (sh_data_next << 1) & wmask;
        if (fb) begin
          crc_next = crc_next ^ (({cfg_reg.terms, 1'b1}) & wmask);            // RQ1 RQ2
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_reg     <= 16'h0000;
      sh_data_reg <= 16'h0000;
      sh_left_reg <= 4'h0;
      eng_reg     <= crc_pkg::eng_idle;
    end else if (wr_en && paddr == crc_pkg::aux_port_off && pstrb[0]) begin
      crc_reg <= pwdata[15:0] & wmask;
    end else if (!frozen && cfg_reg.run) begin                                // RQ16
      if (pop) begin
        sh_data_reg <= fifo_reg[rd_ptr_reg];
        sh_left_reg <= 4'(word_bits[4:1] + {3'b000, word_bits[0]});           // RQ8
        eng_reg     <= crc_pkg::eng_shift;
        if (eng_reg == crc_pkg::eng_shift) begin
          crc_reg <= crc_next;
        end
      end else if (eng_reg == crc_pkg::eng_shift) begin
        crc_reg     <= crc_next;                                              // RQ8
        sh_data_reg <= sh_data_next;
        sh_left_reg <= sh_left_reg - 4'h1;
        if (sh_left_reg <= 4'h1) begin
          eng_reg <= crc_pkg::eng_idle;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= 32'h0000_0000;
      case (paddr)
        crc_pkg::ctrl_off: begin
          prdata[crc_pkg::len_lsb +: 4]   <= cfg_reg.len;
          prdata[crc_pkg::run_bit]        <= cfg_reg.run;
          prdata[crc_pkg::empty_bit]      <= empty_flag;                      // RQ19
          prdata[crc_pkg::full_bit]       <= full_flag;
          prdata[crc_pkg::count_lsb +: 5] <= count_reg;
          prdata[crc_pkg::idle_bit]       <= cfg_reg.halt_in_idle;
        end
        crc_pkg::poly_off:      prdata[15:0] <= {cfg_reg.terms, 1'b0};        // RQ20
        crc_pkg::word_port_off: prdata[15:0] <= crc_reg;
        crc_pkg::aux_port_off:  prdata[15:0] <= crc_reg;
        crc_pkg::power_off:     prdata[1:0]  <= {idle_reg, sleep_reg};
        default:                prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_depth;
    @(posedge pclk) disable iff (!presetn)
      count_reg <= depth;
  endproperty
  a_depth: assert property (p_depth) else $error("count above depth"); // RQ9

  property p_wrap;
    @(posedge pclk) disable iff (!presetn)
      (push && full_flag) |=> (count_reg == 5'h00 && !drained_reg);
  endproperty
  a_wrap: assert property (p_wrap) else $error("full write did not wrap"); // RQ10

  property p_drain;
    @(posedge pclk) disable iff (!presetn)
      ($past(count_reg) == 5'h01 && count_reg == 5'h00 && !$past(push && full_flag))
      |-> drained_reg;
  endproperty
  a_drain: assert property (p_drain) else $error("no drain event"); // RQ12

  property p_frozen;
    @(posedge pclk) disable iff (!presetn)
      (frozen && !push) |=> $stable(count_reg);
  endproperty
  a_frozen: assert property (p_frozen) else $error("count moved while frozen"); // RQ17

  property p_stop;
    @(posedge pclk) disable iff (!presetn)
      !cfg_reg.run |-> !pop;
  endproperty
  a_stop: assert property (p_stop) else $error("pop while stopped"); // RQ16

  // a word taken from the fifo starts a shift sequence at once
  sequence s_take;
    pop && !(push && full_flag);
  endsequence

  sequence s_loaded;
    eng_reg == crc_pkg::eng_shift && sh_left_reg != 4'h0;
  endsequence

  property p_load;
    @(posedge pclk) disable iff (!presetn)
      s_take |=> s_loaded;
  endproperty
  a_load: assert property (p_load) else $error("word not loaded into shifter"); // RQ7

  // each running cycle without a new word spends one shift step
  property p_step;
    @(posedge pclk) disable iff (!presetn)
      (eng_reg == crc_pkg::eng_shift && !frozen && cfg_reg.run && !aux_wr && !pop)
      |=> (sh_left_reg == $past(sh_left_reg) - 4'h1);
  endproperty
  a_step: assert property (p_step) else $error("shift step count wrong"); // RQ8

  // status is latched at the setup edge, one cycle before the master takes it
  sequence s_ctrl_setup;
    psel && !penable && !pwrite && paddr == crc_pkg::ctrl_off;
  endsequence

  property p_ctrl_read;
    @(posedge pclk) disable iff (!presetn)
      s_ctrl_setup |=> (prdata[crc_pkg::empty_bit] == $past(empty_flag) &&
                        prdata[crc_pkg::full_bit] == $past(full_flag));
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("status bits misread"); // RQ19

  // the unimplemented lowest term never shows up on a read
  property p_poly_read;
    @(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && paddr == crc_pkg::poly_off) |=> !prdata[0];
  endproperty
  a_poly_read: assert property (p_poly_read) else $error("term bit zero set"); // RQ20
endmodule // programmable_crc_generator
`default_nettype wire

// *** test/testbench.sv ***
// self-checking bench for the programmable checksum generator
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        word_drained;
  logic [32:0] exp_q[$];
  logic [32:0] note;
  logic [31:0] seed = 32'h00017593;
  logic [31:0] r;
  logic [31:0] ctl;
  logic [15:0] crc;
  logic [15:1] terms;
  logic [3:0]  len;
  int          n_errors = 0;
  int          samples_checked = 0;
  int          n_drain = 0;
  int          prev;
  int          n;
  int          t;

  programmable_crc_generator u_dut (
    .pclk         (pclk),
    .presetn      (presetn),
    .psel         (psel),
    .penable      (penable),
    .pwrite       (pwrite),
    .paddr        (paddr),
    .pwdata       (pwdata),
    .pstrb        (pstrb),
    .prdata       (prdata),
    .pready       (pready),
    .pslverr      (pslverr),
    .word_drained (word_drained)
  );

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // bitwise reference: register of len+1 bits, data msb first
  function automatic logic [15:0] crc_step(logic [15:0] c, logic [3:0] l, logic [15:1] x,
                                           logic [15:0] w);
    logic [15:0] mask;
    logic        fb;
    mask = 16'hffff >> (4'hf - l);
    for (int i = 15; i >= 0; i--) begin
      if (i <= l) begin
        fb = c[l] ^ w[i];
        c = (c << 1) & mask;
        if (fb) c ^= {x, 1'b1} & mask;
      end
    end
    return c;
  endfunction

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // one apb transfer; reads leave their expectation in the queue
  task xfer(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
            input logic [32:0] e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    if (!wr) exp_q.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    forever begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task wreg(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 4'hf, 33'h0);
  endtask

  task rd(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0, 4'h0, {1'b0, e});
  endtask

  // long words need the upper lane to complete the push
  task push(input logic [3:0] l, input logic [15:0] w);
    xfer(1'b1, crc_pkg::word_port_off, {16'h0, w}, (l > crc_pkg::deep_len_max) ? 4'h3 : 4'h1,
         33'h0);
  endtask

  // ----------------------------------------
  // monitor
  // ----------------------------------------
  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
      note = exp_q.pop_front();
      check("prdata", prdata, note[31:0]);
      check("pslverr", {31'h0, pslverr}, {31'h0, note[32]});
    end
    if (word_drained === 1'b1) n_drain++;
  end

  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    $display("timeout waiting for the design");
    print_verdict();
  end

  // ----------------------------------------
  // stimulus
  // ----------------------------------------
  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
    pstrb   = 4'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(crc_pkg::ctrl_off, 32'h00000040);
    rd(crc_pkg::poly_off, 32'h00000000);
    xfer(1'b0, 12'h014, 32'h0, 4'h0, {1'b1, 32'h0});
    wreg(crc_pkg::poly_off, 32'h0000ffff);
    rd(crc_pkg::poly_off, 32'h0000fffe);
    for (int k = 0; k < 2; k++) begin
      len = k ? 4'hf : 4'h7;
      n = k ? 8 : 16;
      wreg(crc_pkg::ctrl_off, {28'h0, len});
      for (int i = 0; i < n; i++) begin
        r = rnd();
        push(len, r[15:0]);
      end
      rd(crc_pkg::ctrl_off, 32'(n << 8) | 32'h80 | {28'h0, len});
      r = rnd();
      push(len, r[15:0]);
      rd(crc_pkg::ctrl_off, 32'h40 | {28'h0, len});
    end
    check("drain pulses", n_drain, 0);
    // runs: idle without halt, frozen by sleep, frozen by idle with halt set
    for (int k = 0; k < 6; k++) begin
      r = rnd();
      len = r[3:0];
      terms = r[19:5];
      n = 3 + k % 3;
      ctl = {28'h0, len} | ((k % 3 == 2) ? 32'h2000 : 32'h0);
      wreg(crc_pkg::ctrl_off, ctl);
      wreg(crc_pkg::poly_off, {16'h0, terms, 1'b0});
      wreg(crc_pkg::aux_port_off, 32'h0);
      crc = 16'h0;
      for (int i = 0; i < n; i++) begin
        r = rnd();
        push(len, r[15:0]);
        crc = crc_step(crc, len, terms, r[15:0]);
      end
      rd(crc_pkg::ctrl_off, ctl | 32'(n << 8));
      // idle without the halt bit must leave the engine running
      wreg(crc_pkg::power_off, (k % 3 == 1) ? 32'h1 : 32'h2);
      prev = n_drain;
      wreg(crc_pkg::ctrl_off, ctl | 32'h10);
      if (k % 3 != 0) begin
        repeat (20) @(posedge pclk);
        rd(crc_pkg::ctrl_off, ctl | 32'h10 | 32'(n << 8));
        wreg(crc_pkg::power_off, 32'h0);
      end
      // top up while the engine is still busy with the primed words
      r = rnd();
      push(len, r[15:0]);
      crc = crc_step(crc, len, terms, r[15:0]);
      t = 0;
      while (n_drain == prev && t < 200) begin
        @(posedge pclk);
        t++;
      end
      repeat (16) @(posedge pclk);
      check("drain pulses", n_drain, prev + 1);
      rd(crc_pkg::ctrl_off, ctl | 32'h50);
      rd(crc_pkg::word_port_off, {16'h0, crc});
    end
    repeat (4) @(posedge pclk);
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
